// File: shared/pfs_pkg.sv
// Purpose: Constants for the supply fault supervisor timing block
// Assumes: 100 MHz clock, one timebase tick per microsecond
// Notes: Times are kept in their printed units and converted to counts here
package pfs_pkg;
  localparam int unsigned PFS_CLK_MHZ = 100;             // Core clock rate in MHz
  localparam int unsigned PFS_TICK_CYC = PFS_CLK_MHZ;    // Cycles per 1 us tick
  localparam logic [6:0] PFS_TICK_LAST = 7'(PFS_TICK_CYC - 1); // Divider wrap value
  // Debounce times in microseconds
  localparam int unsigned PFS_OV_DEB_US = 6;             // Overvoltage debounce
  localparam int unsigned PFS_UV_FAST_US = 6;            // +/-12V undervoltage debounce
  localparam int unsigned PFS_UV_SLOW_US = 450;          // +5V, 3V3 and aux UV debounce
  // Longer intervals in microseconds (ms figures times 1000)
  localparam int unsigned PFS_BLANK_MS = 64;             // UV blanking after start
  localparam int unsigned PFS_PGOOD_MS = 250;            // Power-good delay
  localparam int unsigned PFS_ONOFF_DLY_US = 2500;       // On/off to fault output delay, 2.5 ms
  localparam int unsigned PFS_ONOFF_DEB_MS = 75;         // On/off minimum level width
  localparam int unsigned PFS_RETRY_MS = 1000;           // Bounce-mode restart wait, 1 s
  localparam int unsigned PFS_SS_MS = 8;                 // Soft-start ramp length
  localparam int unsigned PFS_BLANK_US = PFS_BLANK_MS * 1000;
  localparam int unsigned PFS_PGOOD_US = PFS_PGOOD_MS * 1000;
  localparam int unsigned PFS_ONOFF_DEB_US = PFS_ONOFF_DEB_MS * 1000;
  localparam int unsigned PFS_RETRY_US = PFS_RETRY_MS * 1000;
  localparam int unsigned PFS_SS_US = PFS_SS_MS * 1000;
  // Soft-start: 2.5 V in 39 mV steps gives 64 steps
  localparam int unsigned PFS_SS_STEPS = 64;
  localparam int unsigned PFS_SS_STEP_US = PFS_SS_US / PFS_SS_STEPS; // 125 us a step
  localparam int unsigned PFS_TW = 20;                   // Width of tick counters
  localparam int unsigned PFS_REF_W = 7;                 // Reference code width, 0..64
  localparam logic [6:0] PFS_REF_TOP = 7'(PFS_SS_STEPS); // Code for 2.5 V
  // Supervisor sequence states
  typedef enum logic [2:0] {
    PFS_OFF,      // Converter held off by request
    PFS_START,    // On request seen, waiting for turn-on delay
    PFS_RUN,      // Converter running
    PFS_FAULT,    // Latched fault
    PFS_STOP      // Off request seen, waiting for turn-off delay
  } pfs_state_t;
endpackage

// File: core/pfs_debounce.sv
// Purpose: Counts tick enables while an input holds and flags when it held long enough
// Assumes: Input is already synchronised; tick is a one-cycle enable
// Notes: Any drop of the input restarts the count from zero
`timescale 1ns/1ps
`default_nettype none
module pfs_debounce #(
  parameter int unsigned WIDTH = 20,
  parameter int unsigned LIMIT = 6
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clear,
  input wire logic tick,
  input wire logic level,
  output logic done
);
  // Elaboration check: the limit must be reachable by the counter
  if (LIMIT < 1 || LIMIT >= (1 << WIDTH)) begin
    $error("pfs_debounce: LIMIT out of range");
  end
  localparam logic [WIDTH-1:0] LIM = WIDTH'(LIMIT); // Count that qualifies
  logic [WIDTH-1:0] count; // Ticks the level has held
  wire at_lim = (count == LIM);
  // Count up while held, saturate at the limit; clear or drop restarts
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (clear || !level) begin
      count <= '0;
    end else if (tick && !at_lim) begin
      count <= count + WIDTH'(1);
    end
  end
  assign done = at_lim;
endmodule
`default_nettype wire

// File: core/pfs_supervisor.sv
// Purpose: Fault debounce, blanking, power-good delay, on/off handling and soft-start
// Assumes: Comparator and pin inputs are asynchronous; 100 MHz clock
// Notes: Open-drain main fault output is given as drive and enable
// Functional notes
// [RULE1] Main OV must persist 6 us to latch
// [RULE2] Main UV debounce: 6 us or 450 us
// [RULE3] Aux OV held 6 us latches aux fault
// [RULE4] Aux UV held 450 us latches aux fault
// [RULE5] Aux UV blanked 64 ms after supply start
// [RULE6] Main UV blanked 64 ms after mains sense
// [RULE7] Power-good rises 250 ms after rails good
// [RULE8] On/off change reaches fault output after 2.5 ms
// [RULE9] On/off level must hold 75 ms
// [RULE10] Reference ramps 0 to 2.5 V in 8 ms
// [RULE11] Main fault released high, sinks when running
// [RULE12] Aux fault drives high on aux overvoltage
// [RULE13] UV fault latches or retries after 1 s
// [RULE14] All timers share one tick, reset at undervoltage
// [RULE15] Low on/off means run, high means off
`timescale 1ns/1ps
`default_nettype none
module pfs_supervisor
  import pfs_pkg::*;
#(
  parameter int unsigned OV_DEB_US = PFS_OV_DEB_US,
  parameter int unsigned UV_FAST_US = PFS_UV_FAST_US,
  parameter int unsigned UV_SLOW_US = PFS_UV_SLOW_US,
  parameter int unsigned BLANK_US = PFS_BLANK_US,
  parameter int unsigned PGOOD_US = PFS_PGOOD_US,
  parameter int unsigned ONOFF_DLY_US = PFS_ONOFF_DLY_US,
  parameter int unsigned ONOFF_DEB_US = PFS_ONOFF_DEB_US,
  parameter int unsigned RETRY_US = PFS_RETRY_US,
  parameter int unsigned SS_STEP_US = PFS_SS_STEP_US
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic supply_ok_in,        // Supply above turn-on threshold
  input wire logic mains_sense_in,      // Mains present
  input wire logic main_ov_in,          // Any main rail overvoltage
  input wire logic uv_12_in,            // +/-12V rail undervoltage
  input wire logic uv_5_3v3_in,         // +5V or 3V3 rail undervoltage
  input wire logic aux_ov_in,           // Auxiliary overvoltage
  input wire logic aux_uv_in,           // Auxiliary undervoltage
  input wire logic remote_on_n,         // On/off request, low runs
  input wire logic bounce_mode,         // 1: retry after 1 s, 0: latch UV
  output logic main_fault_out,          // Open-drain level, always 0 when driven
  output logic main_fault_oe,           // High while sinking
  output logic aux_fault_out,           // Crowbar drive
  output logic power_good_out,          // Power good
  output logic [PFS_REF_W-1:0] ss_ref   // Reference code, 64 is 2.5 V
);
  // Elaboration checks: blanking, power-good, retry and on/off intervals must fit the tick counters, and the on/off
  // delay may not pass the retry wait, because both run on one saturating counter
  if (BLANK_US >= (1 << PFS_TW) || PGOOD_US >= (1 << PFS_TW) || RETRY_US >= (1 << PFS_TW) ||
      ONOFF_DEB_US >= (1 << PFS_TW) || ONOFF_DLY_US > RETRY_US) begin
    $error("pfs_supervisor: interval too long for counters");
  end
  if (SS_STEP_US < 1 || ONOFF_DLY_US < 1) begin
    $error("pfs_supervisor: zero interval");
  end

  // Two-flop synchronisers for all asynchronous inputs
  // The mode strap is synchronised too, so a strap that moves late cannot split a decision
  // Stages reset low; the on/off debounce hides the run request that this implies
  localparam int unsigned NS = 9;
  logic [NS-1:0] sync_a; // First stage, read only by second stage
  logic [NS-1:0] sync_b; // Safe, synchronised copy
  wire [NS-1:0] raw = {bounce_mode, supply_ok_in, mains_sense_in, main_ov_in, uv_12_in,
                       uv_5_3v3_in, aux_ov_in, aux_uv_in, remote_on_n};
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
    end
  end
  wire s_mode = sync_b[8];
  wire s_vdd = sync_b[7];
  wire s_mains = sync_b[6];
  wire s_mov = sync_b[5];
  wire s_uv12 = sync_b[4];
  wire s_uv5 = sync_b[3];
  wire s_aov = sync_b[2];
  wire s_auv = sync_b[1];
  wire s_onn = sync_b[0];

  // Timers are cleared while the supply is below its turn-on level
  // Holding everything in clear gives a clean start when the supply returns
  wire clr = !s_vdd; // [RULE14]

  // One microsecond timebase enable
  // Every interval counts this enable, so each is quantised to one tick
  // The divider restarts with the supply, so the first tick comes a full tick later
  logic [6:0] div; // Cycle divider
  wire tick = (div == PFS_TICK_LAST);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div <= '0;
    end else if (clr || tick) begin
      div <= '0; // [RULE14]
    end else begin
      div <= div + 7'(1);
    end
  end

  // Saturating up-counter step used by interval timers
  // Saturation keeps a finished timer at its limit instead of wrapping to zero
  function automatic logic [PFS_TW-1:0] step(input logic [PFS_TW-1:0] c, input logic t,
                                             input logic [PFS_TW-1:0] lim);
    step = (t && c != lim) ? c + PFS_TW'(1) : c;
  endfunction

  // Debouncers; each qualifies a persistent condition
  // Resolution is one tick: a level qualifies after LIMIT-1 to LIMIT ticks of hold,
  // which keeps the shortest accepted pulse inside the allowed window
  // Aux UV counting is gated by its blanking, so a start-up sag never reaches the latch
  logic ov_ok, uv12_ok, uv5_ok, aov_ok, auv_ok, on_stable_ok;
  logic aux_armed, main_armed;
  pfs_debounce #(.WIDTH(PFS_TW), .LIMIT(OV_DEB_US)) u_mov (
    .clock(clock), .rst(rst), .clear(clr), .tick(tick), .level(s_mov), .done(ov_ok)); // [RULE1]
  pfs_debounce #(.WIDTH(PFS_TW), .LIMIT(UV_FAST_US)) u_uv12 (
    .clock(clock), .rst(rst), .clear(clr), .tick(tick), .level(s_uv12), .done(uv12_ok)); // [RULE2]
  pfs_debounce #(.WIDTH(PFS_TW), .LIMIT(UV_SLOW_US)) u_uv5 (
    .clock(clock), .rst(rst), .clear(clr), .tick(tick), .level(s_uv5), .done(uv5_ok)); // [RULE2]
  pfs_debounce #(.WIDTH(PFS_TW), .LIMIT(OV_DEB_US)) u_aov (
    .clock(clock), .rst(rst), .clear(clr), .tick(tick), .level(s_aov), .done(aov_ok)); // [RULE3]
  pfs_debounce #(.WIDTH(PFS_TW), .LIMIT(UV_SLOW_US)) u_auv (
    .clock(clock), .rst(rst), .clear(clr), .tick(tick), .level(s_auv && aux_armed),
    .done(auv_ok)); // [RULE4]

  // Aux UV blanking from supply start
  // Counts from the supply turn-on and stays armed until the supply drops again
  logic [PFS_TW-1:0] aux_blank; // Ticks since supply start
  localparam logic [PFS_TW-1:0] BLANK_LIM = PFS_TW'(BLANK_US);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) aux_blank <= '0;
    else if (clr) aux_blank <= '0;
    else aux_blank <= step(aux_blank, tick, BLANK_LIM); // [RULE5]
  end
  assign aux_armed = (aux_blank == BLANK_LIM); // [RULE5]

  // Main UV blanking from mains sense going high
  // A mains dip restarts the blanking: main UV is hidden for a full interval again,
  // traded against false trips while the rails recover
  logic [PFS_TW-1:0] main_blank; // Ticks since mains present
  always_ff @(posedge clock or posedge rst) begin
    if (rst) main_blank <= '0;
    else if (clr || !s_mains) main_blank <= '0;
    else main_blank <= step(main_blank, tick, BLANK_LIM); // [RULE6]
  end
  assign main_armed = (main_blank == BLANK_LIM); // [RULE6]

  // Aux fault latches: a debounced OV or UV holds the output high until restart
  // The output carries crowbar current, so it must not chatter once set
  // Clear wins over a fault in the same cycle; it only comes with the supply going away
  logic aux_ov_latch, aux_uv_latch;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aux_ov_latch <= 1'b0;
      aux_uv_latch <= 1'b0;
    end else if (clr) begin
      aux_ov_latch <= 1'b0; // Latch released only by restart
      aux_uv_latch <= 1'b0;
    end else begin
      if (aov_ok) aux_ov_latch <= 1'b1; // [RULE3]
      if (auv_ok) aux_uv_latch <= 1'b1; // [RULE4]
    end
  end
  assign aux_fault_out = aux_ov_latch || aux_uv_latch; // [RULE4] [RULE12]

  // On/off debounce: a level must hold 75 ms to be accepted
  // The count runs only while the pin differs from the accepted level;
  // any return to the accepted level throws the partial count away
  logic on_req;   // Accepted level, 1 means run
  logic [PFS_TW-1:0] on_cnt; // Ticks the candidate level has held
  localparam logic [PFS_TW-1:0] DEB_LIM = PFS_TW'(ONOFF_DEB_US);
  wire on_raw = !s_onn; // [RULE15]
  wire on_diff = (on_raw != on_req);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      on_cnt <= '0;
      on_req <= 1'b0;
    end else if (clr) begin
      on_cnt <= '0;
      on_req <= 1'b0;
    end else if (!on_diff) begin
      on_cnt <= '0; // Short pulse rejected [RULE9]
    end else if (on_cnt == DEB_LIM) begin
      on_req <= on_raw; // [RULE9]
      on_cnt <= '0;
    end else begin
      on_cnt <= step(on_cnt, tick, DEB_LIM);
    end
  end
  assign on_stable_ok = !on_diff;

  // Sequence: on/off delay, run, fault and retry
  // OFF waits for an accepted run request, START times the turn-on delay,
  // RUN watches the debounced faults, STOP times the turn-off delay,
  // FAULT holds the converter off until an off request or a UV retry
  // An OV fault never retries; only an undervoltage may bounce
  pfs_state_t state, next_state;
  logic [PFS_TW-1:0] seq_cnt; // Shared delay counter for the sequence
  localparam logic [PFS_TW-1:0] DLY_LIM = PFS_TW'(ONOFF_DLY_US);
  localparam logic [PFS_TW-1:0] RETRY_LIM = PFS_TW'(RETRY_US);
  wire main_uv = (uv12_ok || uv5_ok) && main_armed; // [RULE6]
  wire uv_fault = main_uv;                          // [RULE2]
  wire dly_done = (seq_cnt == DLY_LIM);
  wire retry_done = (seq_cnt == RETRY_LIM);
  logic uv_cause; // Fault came from undervoltage
  always_comb begin
    next_state = state;
    case (state)
      PFS_OFF: if (on_req && on_stable_ok) next_state = PFS_START;
      PFS_START: if (!on_req) next_state = PFS_OFF;
                 else if (dly_done) next_state = PFS_RUN; // [RULE8]
      PFS_RUN: if (ov_ok || uv_fault) next_state = PFS_FAULT; // [RULE1]
               else if (!on_req) next_state = PFS_STOP;
      PFS_STOP: if (on_req) next_state = PFS_RUN;
                else if (dly_done) next_state = PFS_OFF; // [RULE8]
      PFS_FAULT: if (!on_req) next_state = PFS_STOP;
                 else if (s_mode && uv_cause && retry_done) next_state = PFS_START; // [RULE13]
      default: next_state = PFS_OFF;
    endcase
  end
  // State register and its delay counter, restarted on every state change
  // One counter serves both delays and the retry wait, as only one runs at a time
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= PFS_OFF;
      seq_cnt <= '0;
      uv_cause <= 1'b0;
    end else if (clr) begin
      state <= PFS_OFF; // [RULE14]
      seq_cnt <= '0;
      uv_cause <= 1'b0;
    end else begin
      state <= next_state;
      seq_cnt <= (next_state != state) ? '0 : step(seq_cnt, tick, RETRY_LIM);
      if (state == PFS_RUN && next_state == PFS_FAULT) uv_cause <= !ov_ok; // [RULE13]
    end
  end

  // Main fault sinks in RUN and through the STOP turn-off delay; released otherwise
  // The enable is registered so the pin never glitches on a state decode
  wire running = (state == PFS_RUN) || (state == PFS_STOP);
  logic mf_sink; // Registered drive enable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) mf_sink <= 1'b0;
    else mf_sink <= running; // [RULE11]
  end
  assign main_fault_out = 1'b0;
  assign main_fault_oe = mf_sink; // [RULE11]

  // Power good after rails good for the delay; a main fault drops it at once, an aux fault leaves it
  // Raw rail flags are used here, so a short sag restarts the whole delay
  logic [PFS_TW-1:0] pg_cnt; // Ticks since main rails good
  logic pg;
  localparam logic [PFS_TW-1:0] PG_LIM = PFS_TW'(PGOOD_US);
  wire rails_good = (state == PFS_RUN) && !s_uv12 && !s_uv5;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pg_cnt <= '0;
      pg <= 1'b0;
    end else if (clr || !rails_good) begin
      pg_cnt <= '0;
      pg <= 1'b0; // [RULE7]
    end else begin
      pg_cnt <= step(pg_cnt, tick, PG_LIM);
      pg <= (pg_cnt == PG_LIM); // [RULE7]
    end
  end
  assign power_good_out = pg;

  // Soft-start ramp: one 39 mV step each 125 us while running
  // The code stops at its top value; leaving the run states drops it to zero,
  // so every restart ramps from the bottom again
  logic [PFS_REF_W-1:0] ref_code;
  logic [PFS_TW-1:0] ss_cnt; // Ticks within the current step
  localparam logic [PFS_TW-1:0] SS_LIM = PFS_TW'(SS_STEP_US - 1);
  wire ss_step = tick && (ss_cnt == SS_LIM);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ref_code <= '0;
      ss_cnt <= '0;
    end else if (clr || !running) begin
      ref_code <= '0; // Ramp restarts on every start
      ss_cnt <= '0;
    end else if (tick && ref_code != PFS_REF_TOP) begin
      ss_cnt <= ss_step ? '0 : ss_cnt + PFS_TW'(1);
      if (ss_step) ref_code <= ref_code + PFS_REF_W'(1); // [RULE10]
    end
  end
  assign ss_ref = ref_code;
endmodule
`default_nettype wire

// File: sim/pfs_host_model.sv
// Purpose: Host on/off driver model
// Assumes: Pin has a pull-up, so it idles high
// Notes: glitch makes a pulse shorter than the hold time
`timescale 1ns/1ps
`default_nettype none
module pfs_host_model #(
  parameter int unsigned HOLD_CYC = 2000
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic want_off, // Level asked for, high is off
  input wire logic glitch, // Deliberate short inversion
  output logic remote_on_n
);
  int unsigned held; // Clocks since the level moved
  logic level; // Level the host holds
  // A level moves only after the last one was held long enough
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      level <= 1'b1;
      held <= HOLD_CYC;
    end else if (want_off != level && held >= HOLD_CYC) begin
      level <= want_off;
      held <= 0;
    end else begin
      held <= held + 1;
    end
  end
  assign remote_on_n = level ^ glitch; // Pull-up gives high in reset
endmodule
`default_nettype wire

// File: sim/pfs_supervisor_checker.sv
// Purpose: Port timing checks for the supervisor
// Assumes: One tick is 100 clocks
// Notes: Counters measure run lengths in clocks
`timescale 1ns/1ps
`default_nettype none
module pfs_supervisor_checker
  import pfs_pkg::*;
#(
  parameter int unsigned OV_DEB_US = 6,
  parameter int unsigned UV_SLOW_US = 450,
  parameter int unsigned PGOOD_US = 250,
  parameter int unsigned ONOFF_DLY_US = 2500,
  parameter int unsigned ONOFF_DEB_US = 75000,
  parameter int unsigned SS_STEP_US = 125
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic supply_ok_in,
  input wire logic main_ov_in,
  input wire logic aux_ov_in,
  input wire logic aux_uv_in,
  input wire logic remote_on_n,
  input wire logic main_fault_out,
  input wire logic main_fault_oe,
  input wire logic aux_fault_out,
  input wire logic power_good_out,
  input wire logic [PFS_REF_W-1:0] ss_ref
);
  int unsigned lo_n, oe_n, aov_n, auv_n, mov_n, gap_n; // Run lengths
  logic [5:0] sok_h; // Recent supply samples
  logic [PFS_REF_W-1:0] prev_ref; // Last reference code
  // Run-length counters behind the timing checks
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lo_n <= 0;
      oe_n <= 0;
      aov_n <= 0;
      auv_n <= 0;
      mov_n <= 0;
      gap_n <= 0;
      sok_h <= 6'h00;
      prev_ref <= 7'h00;
    end else begin
      lo_n <= remote_on_n ? 0 : lo_n + 1;
      oe_n <= main_fault_oe ? oe_n + 1 : 0;
      aov_n <= aux_ov_in ? aov_n + 1 : 0;
      auv_n <= aux_uv_in ? auv_n + 1 : 0;
      mov_n <= main_ov_in ? mov_n + 1 : 0;
      gap_n <= (ss_ref != prev_ref) ? 1 : gap_n + 1;
      sok_h <= {sok_h[4:0], supply_ok_in};
      prev_ref <= ss_ref;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence oe_on_s;
    $rose(main_fault_oe);
  endsequence
  od_low_a: assert property (main_fault_out == 1'b0)
    else $error("main fault data not low");
  on_delay_a: assert property (oe_on_s |-> lo_n >= (ONOFF_DEB_US + ONOFF_DLY_US - 1) * 100)
    else $error("run started too early");
  pg_delay_a: assert property ($rose(power_good_out) |-> oe_n >= (PGOOD_US - 1) * 100)
    else $error("power good too early");
  aux_deb_a: assert property ($rose(aux_fault_out) |-> aov_n >= (OV_DEB_US - 1) * 100 ||
    auv_n >= (UV_SLOW_US - 1) * 100)
    else $error("aux fault too early");
  aux_hold_a: assert property ($fell(aux_fault_out) |-> sok_h != 6'h3F)
    else $error("aux fault dropped");
  ov_trip_a: assert property (mov_n > (OV_DEB_US + 2) * 100 |-> !main_fault_oe)
    else $error("overvoltage not acted on");
  ref_step_a: assert property ($changed(ss_ref) |-> ss_ref == $past(ss_ref) + 7'h01 || ss_ref == 7'h00)
    else $error("reference step wrong");
  ref_top_a: assert property (ss_ref <= PFS_REF_TOP)
    else $error("reference above top");
  ref_gap_a: assert property ($changed(ss_ref) && ss_ref != 7'h00 |-> gap_n >= SS_STEP_US * 100 - 1)
    else $error("reference stepped too fast");
endmodule
bind pfs_supervisor pfs_supervisor_checker #(.OV_DEB_US(OV_DEB_US), .UV_SLOW_US(UV_SLOW_US), .PGOOD_US(PGOOD_US),
  .ONOFF_DLY_US(ONOFF_DLY_US), .ONOFF_DEB_US(ONOFF_DEB_US), .SS_STEP_US(SS_STEP_US)) u_chk (
  .clock, .rst, .supply_ok_in, .main_ov_in, .aux_ov_in, .aux_uv_in, .remote_on_n, .main_fault_out,
  .main_fault_oe, .aux_fault_out, .power_good_out, .ss_ref);
`default_nettype wire

// File: sim/psu_fault_supervisor_timing_tb_top.sv
// Purpose: Self-checking bench for the supervisor
// Assumes: Shortened timers, one tick is 100 clocks
// Notes: Timers are shortened so the whole run stays short
`timescale 1ns/1ps
`default_nettype none
module psu_fault_supervisor_timing_tb_top;
  import pfs_pkg::*;
  localparam int T = 100, OV = 3, UVF = 3, UVS = 8, PG = 40, DLY = 10, DEB = 20, RET = 50, SS = 1;
  logic clock, rst, supply_ok_in, mains_sense_in, main_ov_in, uv_12_in, uv_5_3v3_in;
  logic aux_ov_in, aux_uv_in, remote_on_n, bounce_mode, want_off, glitch;
  logic main_fault_out, main_fault_oe, aux_fault_out, power_good_out;
  logic [PFS_REF_W-1:0] ss_ref;
  int checks, miscompares, cyc, n;
  pfs_supervisor #(.OV_DEB_US(OV), .UV_FAST_US(UVF), .UV_SLOW_US(UVS), .BLANK_US(15), .PGOOD_US(PG),
    .ONOFF_DLY_US(DLY), .ONOFF_DEB_US(DEB), .RETRY_US(RET), .SS_STEP_US(SS)) dut (
    .clock, .rst, .supply_ok_in, .mains_sense_in, .main_ov_in, .uv_12_in, .uv_5_3v3_in, .aux_ov_in,
    .aux_uv_in, .remote_on_n, .bounce_mode, .main_fault_out, .main_fault_oe, .aux_fault_out,
    .power_good_out, .ss_ref);
  pfs_host_model #(.HOLD_CYC(DEB * T)) host (.clock, .rst, .want_off, .glitch, .remote_on_n);
  // Expected reference code a number of ticks into the ramp
  function automatic logic [6:0] exp_ref(input int t);
    return (t / SS >= 64) ? PFS_REF_TOP : 7'(t / SS);
  endfunction
  function automatic logic cur(input int s);
    return s == 0 ? main_fault_oe : (s == 1 ? power_good_out : aux_fault_out);
  endfunction
  task automatic chk(input logic ok, input string what);
    checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask
  task automatic tk(input int k);
    repeat (k * T) @(posedge clock);
    #1;
  endtask
  // Waits for an output level, then checks how long it took
  task automatic wait_for(input int s, input logic v, input int lo, input int hi, input string what);
    n = 0;
    while (cur(s) !== v && n < hi * T) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk(cur(s) === v && n >= lo * T, what);
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Hang guard sized from the planned run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 80000) begin
      miscompares++;
      $display("[ERR] %0t timeout", $time);
      results;
    end
  end
  initial begin
    {rst, supply_ok_in, mains_sense_in, main_ov_in, uv_12_in, uv_5_3v3_in} = 6'h20;
    {aux_ov_in, aux_uv_in, bounce_mode, want_off, glitch} = 5'h06;
    checks = 0;
    miscompares = 0;
    cyc = 0;
    n = $urandom(46);
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    supply_ok_in <= 1'b1;
    mains_sense_in <= 1'b1;
    want_off <= 1'b0;
    aux_uv_in <= 1'b1; // Inside blanking, must be ignored
    tk(10);
    aux_uv_in <= 1'b0;
    chk(power_good_out === 1'b0 && main_fault_oe === 1'b0, "early run");
    chk(aux_fault_out === 1'b0, "aux uv not blanked");
    wait_for(0, 1'b1, DEB + DLY - 11, DEB + DLY - 7, "start delay");
    wait_for(1, 1'b1, PG - 1, PG + 3, "power good delay");
    chk(ss_ref + 7'h02 >= exp_ref(PG) && ss_ref <= exp_ref(PG) + 7'h02, "ramp mid");
    tk(30);
    chk(ss_ref === exp_ref(PG + 30), "ramp end");
    $display("startup done");
    repeat (2) begin
      @(posedge clock) glitch <= 1'b1;
      tk($urandom_range(3, DEB - 5));
      glitch <= 1'b0;
      tk(DEB + DLY + 3);
      chk(main_fault_oe === 1'b1, "short off pulse acted on");
    end
    $display("glitch done");
    repeat (3) begin
      @(posedge clock) aux_ov_in <= 1'b1;
      repeat ($urandom_range(10, (OV - 1) * T - 20)) @(posedge clock);
      aux_ov_in <= 1'b0;
      tk(1);
      chk(aux_fault_out === 1'b0, "short aux pulse latched");
    end
    aux_ov_in <= 1'b1;
    wait_for(2, 1'b1, OV - 1, OV + 3, "aux trip");
    aux_ov_in <= 1'b0;
    tk(5);
    chk(aux_fault_out === 1'b1, "aux latch lost");
    $display("aux done");
    @(posedge clock) want_off <= 1'b1;
    wait_for(0, 1'b0, DEB + DLY - 1, DEB + DLY + 3, "off delay");
    want_off <= 1'b0;
    wait_for(0, 1'b1, DEB + DLY - 1, DEB + DLY + 3, "on again");
    $display("on off done");
    @(posedge clock) mains_sense_in <= 1'b0;
    tk(1);
    mains_sense_in <= 1'b1; // Main UV blanking restarts here
    uv_12_in <= 1'b1;
    tk(10);
    uv_12_in <= 1'b0;
    tk(6);
    chk(main_fault_oe === 1'b1, "main uv not blanked");
    $display("blanking done");
    @(posedge clock) uv_12_in <= 1'b1;
    repeat ($urandom_range(10, (UVF - 1) * T - 20)) @(posedge clock);
    uv_12_in <= 1'b0;
    tk(2);
    chk(main_fault_oe === 1'b1, "short uv pulse acted on");
    @(posedge clock) uv_12_in <= 1'b1;
    wait_for(0, 1'b0, UVF - 1, UVF + 3, "uv 12 trip");
    uv_12_in <= 1'b0;
    wait_for(0, 1'b1, RET - 1, RET + DEB + DLY + 5, "retry");
    $display("bounce done");
    @(posedge clock) main_ov_in <= 1'b1;
    wait_for(0, 1'b0, OV - 1, OV + 3, "ov trip");
    tk(30);
    chk(main_fault_oe === 1'b0, "ov not latched");
    supply_ok_in <= 1'b0;
    main_ov_in <= 1'b0;
    tk(1);
    chk(aux_fault_out === 1'b0 && power_good_out === 1'b0 && ss_ref === 7'h00, "clear");
    supply_ok_in <= 1'b1;
    bounce_mode <= 1'b0;
    wait_for(0, 1'b1, DEB + DLY - 1, DEB + DLY + 3, "restart");
    $display("ov done");
    @(posedge clock) uv_5_3v3_in <= 1'b1;
    wait_for(0, 1'b0, UVS - 1, UVS + 3, "uv 5 trip");
    uv_5_3v3_in <= 1'b0;
    tk(RET + DEB + DLY + 5);
    chk(main_fault_oe === 1'b0, "latched uv retried");
    $display("latch done");
    @(posedge clock) aux_uv_in <= 1'b1;
    wait_for(2, 1'b1, UVS - 1, UVS + 3, "aux uv trip");
    aux_uv_in <= 1'b0;
    tk(2);
    chk(aux_fault_out === 1'b1, "aux uv latch lost");
    $display("aux uv done");
    results;
  end
endmodule
`default_nettype wire
